// ===== hdl/atpc_capture.sv
/*
 * atpc_capture: touch-probe position capture for one axis channel,
 * with APB registers, scan-period enable and a level interrupt.
 * Assumes synchronous pins, a 250 MHz clock and free-running
 * 32-bit pulse counters from the encoder port and the servo drive.
 */
// Local design decisions: the placing of the registers and the APB register port.
// Functional notes
// - start only on execute rise; sample inputs
// - mode 0 latches on local rising edge
// - mode 1 latches on local falling edge
// - select 0..15 picks I0..I7, I10..I17
// - mode 5 latches on aux input rise
// - mode 6 latches on aux input fall
// - mode 7 latches on either aux edge
// - mode 8 latches on index rising edge
// - no duplicate capture on one local input
// - one capture per axis in modes 5..8
// - done rises when position is recorded
// - busy holds while request is processed
// - active holds while waiting on the axis
// - aborted flag when capture is preempted
// - error flag with 16-bit fault code
// - 64-bit float position valid after done
module atpc_capture #(
    parameter int NUM_AXES    = 4,                      // axes served
    parameter int SCAN_CYCLES = atpc_pkg::SCAN_CYCLES   // scan period
) (
    input  wire logic        clk_sys_in,        // system clock
    input  wire logic        rst_b_in,          // sync reset, active low
    input  wire logic        psel,              // apb select
    input  wire logic        penable,           // apb enable
    input  wire logic        pwrite,            // apb write
    input  wire logic [7:0]  paddr,             // apb byte address
    input  wire logic [31:0] pwdata,            // apb write data
    output logic      [31:0] prdata,            // apb read data
    output logic             pready,            // apb ready
    output logic             pslverr,           // apb error
    input  wire logic [15:0] local_inputs_in,   // local inputs
    input  wire logic        drive_aux_input_13_in, // drive aux input
    input  wire logic        drive_index_in,    // drive encoder index
    input  wire logic [31:0] ext_count_in,      // encoder port count
    input  wire logic [31:0] servo_count_in,    // servo feedback count
    input  wire logic        abort_in,          // preempting command
    output logic             done_out,          // capture done
    output logic             busy_out,          // request in progress
    output logic             active_out,        // waiting on axis
    output logic             aborted_out,       // capture preempted
    output logic             error_out,         // fault present
    output logic             irq_out            // interrupt, level
);
    import atpc_pkg::*;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // extend a wrapping 32-bit counter into a running 64-bit count
    function automatic logic [63:0] unwrap(input logic [63:0] acc,
                                           input logic [31:0] cur,
                                           input logic [31:0] prev);
        logic [31:0] d;
        d = cur - prev;
        return acc + {{32{d[31]}}, d};
    endfunction : unwrap

    // signed 64-bit integer to ieee double, truncating low bits
    function automatic logic [63:0] to_dbl(input logic [63:0] v);
        logic [63:0] mag;
        logic [10:0] ex;
        logic [63:0] sh;
        int          pos;
        mag = v[63] ? (~v + 64'h1) : v;
        pos = 0;
        for (int i = 0; i < 64; i++) begin
            if (mag[i]) begin
                pos = i;
            end
        end
        ex = 11'(1023 + pos);
        sh = mag << (63 - pos);
        if (mag == 64'h0) begin
            return 64'h0;
        end
        return {v[63], ex, sh[62:11]};
    endfunction : to_dbl

    atpc_state_e state;
    logic [31:0] ctrl;
    logic        exec_prev;
    logic        exec_rise;
    logic [3:0]  mode_q;
    logic [3:0]  sel_q;
    logic        hold_wait;
    logic        done_q;
    logic        aborted_q;
    logic        error_q;
    logic [15:0] fault_code;
    logic [63:0] latched_position;
    logic [63:0] ext_acc;
    logic [63:0] servo_acc;
    logic [31:0] ext_prev;
    logic [31:0] servo_prev;
    logic [63:0] next_pos;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_mask;
    logic [3:0]  irq_set;
    logic [31:0] scan_cnt;
    logic        scan_tick;
    logic        trig;
    logic        wr_en;
    logic        setup;
    logic        mapped;
    logic        mode_ok;
    logic        axis_ok;
    logic        busy;

    // ------------------------------------------------------------
    // scan period enable
    // ------------------------------------------------------------
    // one-cycle tick every scan period; active and the delayed flag clear step on this grid
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            scan_cnt <= 32'h0;
        end else if (scan_cnt == 32'(SCAN_CYCLES - 1)) begin
            scan_cnt <= 32'h0;
        end else begin
            scan_cnt <= scan_cnt + 32'h1;
        end
    end
    assign scan_tick = (scan_cnt == 32'(SCAN_CYCLES - 1));

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    // zero wait states: read data is loaded in the setup cycle
    assign pready = 1'b1;
    assign setup  = psel & ~penable;
    assign wr_en  = psel & penable & pwrite & mapped;

    // address decode, unmapped answers with pslverr
    always_comb begin
        if (paddr == OFS_CTRL) begin
            mapped = 1'b1;
        end else if (paddr == OFS_STATUS || paddr == OFS_FAULT) begin
            mapped = 1'b1;
        end else if (paddr == OFS_POS_LO || paddr == OFS_POS_HI) begin
            mapped = 1'b1;
        end else if (paddr == OFS_IRQ_STAT || paddr == OFS_IRQ_MASK) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end
    assign pslverr = psel & penable & ~mapped;

    // read data register
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            prdata <= 32'h0;
        end else if (setup && !pwrite) begin
            if (paddr == OFS_CTRL) begin
                prdata <= ctrl;
            end else if (paddr == OFS_STATUS) begin
                prdata <= {27'h0, error_q, aborted_q, active_out, busy, done_q};
            end else if (paddr == OFS_FAULT) begin
                prdata <= {16'h0, fault_code};
            end else if (paddr == OFS_POS_LO) begin
                prdata <= latched_position[31:0];
            end else if (paddr == OFS_POS_HI) begin
                prdata <= latched_position[63:32];
            end else if (paddr == OFS_IRQ_STAT) begin
                prdata <= {28'h0, irq_stat};
            end else if (paddr == OFS_IRQ_MASK) begin
                prdata <= {28'h0, irq_mask};
            end else begin
                prdata <= 32'h0;
            end
        end
    end

    // control register; execute edge is taken from its bit
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            ctrl      <= CTRL_RESET;
            exec_prev <= 1'b0;
        end else begin
            exec_prev <= ctrl[CTRL_EXEC_BIT];
            if (wr_en && paddr == OFS_CTRL) begin
                ctrl <= pwdata;
            end
        end
    end
    assign exec_rise = ctrl[CTRL_EXEC_BIT] & ~exec_prev;

    // ------------------------------------------------------------
    // position sources
    // ------------------------------------------------------------
    // running counts keep climbing across the 32-bit wrap
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            ext_acc    <= 64'h0;
            servo_acc  <= 64'h0;
            ext_prev   <= 32'h0;
            servo_prev <= 32'h0;
        end else begin
            ext_prev   <= ext_count_in;
            servo_prev <= servo_count_in;
            ext_acc    <= unwrap(ext_acc, ext_count_in, ext_prev);
            servo_acc  <= unwrap(servo_acc, servo_count_in, servo_prev);
        end
    end

    // local modes count the encoder port, drive modes the servo
    always_comb begin
        if (mode_q == MODE_LOCAL_RISE || mode_q == MODE_LOCAL_FALL) begin
            next_pos = to_dbl(ext_acc);
        end else begin
            next_pos = to_dbl(servo_acc);
        end
    end

    // ------------------------------------------------------------
    // trigger detection
    // ------------------------------------------------------------
    atpc_trig u_trig (
        .clk_sys_in (clk_sys_in),
        .rst_b_in   (rst_b_in),
        .local_in   (local_inputs_in),
        .aux_in     (drive_aux_input_13_in),
        .index_in   (drive_index_in),
        .mode_in    (mode_q),
        .sel_in     (sel_q),
        .trig_out   (trig)
    );

    // ------------------------------------------------------------
    // capture sequence
    // ------------------------------------------------------------
    assign mode_ok = ctrl[CTRL_MODE_LSB +: 4] inside {MODE_LOCAL_RISE, MODE_LOCAL_FALL,
                     MODE_AUX_RISE, MODE_AUX_FALL, MODE_AUX_BOTH, MODE_INDEX_RISE};
    assign axis_ok = 32'(ctrl[CTRL_AXIS_LSB +: 4]) < NUM_AXES;
    assign busy    = (state == ATPC_BUSY) | (state == ATPC_ARMED);

    // one channel: a second start while busy is refused, which
    // covers both the same-input and the same-axis duplicate
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            state            <= ATPC_IDLE;
            mode_q           <= MODE_LOCAL_RISE;
            sel_q            <= 4'h0;
            done_q           <= 1'b0;
            aborted_q        <= 1'b0;
            error_q          <= 1'b0;
            hold_wait        <= 1'b0;
            fault_code       <= FAULT_NONE;
            latched_position <= 64'h0;
        end else begin
            case (state)
                ATPC_IDLE: begin
                    if (exec_rise) begin
                        mode_q <= ctrl[CTRL_MODE_LSB +: 4];
                        sel_q  <= ctrl[CTRL_SEL_LSB +: 4];
                        done_q <= 1'b0;
                        if (!mode_ok) begin
                            error_q    <= 1'b1;
                            fault_code <= FAULT_MODE;
                            hold_wait  <= 1'b0;
                            state      <= ATPC_HOLD;
                        end else if (!axis_ok) begin
                            error_q    <= 1'b1;
                            fault_code <= FAULT_AXIS;
                            hold_wait  <= 1'b0;
                            state      <= ATPC_HOLD;
                        end else begin
                            fault_code <= FAULT_NONE;
                            state      <= ATPC_BUSY;
                        end
                    end
                end
                ATPC_BUSY: begin
                    // active follows busy at the next scan tick
                    if (abort_in) begin
                        aborted_q <= 1'b1;
                        hold_wait <= ~ctrl[CTRL_EXEC_BIT];
                        state     <= ATPC_HOLD;
                    end else if (scan_tick) begin
                        state <= ATPC_ARMED;
                    end
                end
                ATPC_ARMED: begin
                    // a preempting command wins over a same-cycle edge
                    if (abort_in) begin
                        aborted_q <= 1'b1;
                        hold_wait <= ~ctrl[CTRL_EXEC_BIT];
                        state     <= ATPC_HOLD;
                    end else if (trig) begin
                        latched_position <= next_pos;
                        done_q           <= 1'b1;
                        hold_wait        <= ~ctrl[CTRL_EXEC_BIT];
                        state            <= ATPC_HOLD;
                    end
                end
                ATPC_HOLD: begin
                    // flags drop when execute falls, or at the next
                    // scan tick if it had already fallen
                    if (!ctrl[CTRL_EXEC_BIT] && (!hold_wait || scan_tick)) begin
                        done_q    <= 1'b0;
                        aborted_q <= 1'b0;
                        error_q   <= 1'b0;
                        state     <= ATPC_IDLE;
                    end
                end
                default: begin
                    state <= ATPC_IDLE;
                end
            endcase
        end
    end

    assign done_out    = done_q;
    assign busy_out    = busy;
    assign active_out  = (state == ATPC_ARMED);
    assign aborted_out = aborted_q;
    assign error_out   = error_q;

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    assign irq_set[IRQ_DONE_BIT]   = (state == ATPC_ARMED) & trig & ~abort_in;
    assign irq_set[IRQ_ABORT_BIT]  = busy & abort_in;
    assign irq_set[IRQ_ERROR_BIT]  = (state == ATPC_IDLE) & exec_rise & ~(mode_ok & axis_ok);
    assign irq_set[IRQ_REJECT_BIT] = busy & exec_rise;

    // sticky, write one to clear; a same-cycle set wins
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            irq_stat <= 4'h0;
            irq_mask <= IRQ_MASK_RESET;
        end else begin
            if (wr_en && paddr == OFS_IRQ_STAT) begin
                irq_stat <= (irq_stat & ~pwdata[3:0]) | irq_set;
            end else begin
                irq_stat <= irq_stat | irq_set;
            end
            if (wr_en && paddr == OFS_IRQ_MASK) begin
                irq_mask <= pwdata[3:0];
            end
        end
    end
    assign irq_out = |(irq_stat & irq_mask);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_b_in);

    a_start_busy:
        assert property (state == ATPC_IDLE && exec_rise && mode_ok && axis_ok
                         |=> busy_out && !active_out)
        else $error("start did not raise busy alone");

    a_mode_illegal:
        assert property (state == ATPC_IDLE && exec_rise && !mode_ok
                         |=> error_out && fault_code == FAULT_MODE && !busy_out)
        else $error("illegal mode not flagged");

    a_active_step:
        assert property (state == ATPC_BUSY && scan_tick && !abort_in
                         |=> active_out && busy_out)
        else $error("active not set after one scan");

    a_busy_held:
        assert property (active_out && !trig && !abort_in |=> busy_out)
        else $error("busy dropped while waiting");

    a_done_pos:
        assert property (active_out && trig && !abort_in
                         |=> done_out && !busy_out && latched_position == $past(next_pos))
        else $error("capture not recorded on trigger");

    a_abort_flag:
        assert property (busy_out && abort_in |=> aborted_out && !busy_out && !done_out)
        else $error("abort not flagged");

    a_fall_local:
        assert property (active_out && mode_q == MODE_LOCAL_FALL && !abort_in
                         && $past(local_inputs_in[sel_q]) && !local_inputs_in[sel_q]
                         |=> done_out)
        else $error("mode 1 falling edge missed");

    a_aux_both:
        assert property (active_out && mode_q == MODE_AUX_BOTH && !abort_in
                         && $changed(drive_aux_input_13_in) |=> done_out)
        else $error("mode 7 edge missed");

    a_dup_reject:
        assert property (busy_out && exec_rise && !abort_in && !trig
                         |=> busy_out && irq_stat[IRQ_REJECT_BIT])
        else $error("duplicate start not refused");

    a_pos_stable:
        assert property (done_out && $past(done_out) |-> $stable(latched_position))
        else $error("position changed while done");

endmodule : atpc_capture

// ===== hdl/atpc_pkg.sv
/*
 * atpc_pkg: shared constants of the axis touch-probe capture block:
 * register map, field positions, reset values, modes, fault codes, timing.
 * Assumes a 250 MHz system clock and a 32-bit APB register port.
 */
package atpc_pkg;

    // ------------------------------------------------------------
    // clock and scan timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 4;
    localparam int SCAN_PERIOD_NS = 1000;
    localparam int SCAN_CYCLES    = (SCAN_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_STATUS   = 8'h04;
    localparam logic [7:0] OFS_FAULT    = 8'h08;
    localparam logic [7:0] OFS_POS_LO   = 8'h0c;
    localparam logic [7:0] OFS_POS_HI   = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

    // ------------------------------------------------------------
    // control field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_EXEC_BIT = 0;
    localparam int CTRL_MODE_LSB = 4;
    localparam int CTRL_SEL_LSB  = 8;
    localparam int CTRL_AXIS_LSB = 16;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
    localparam logic [3:0]  IRQ_MASK_RESET = 4'h0;

    // status bits: done, busy, active, aborted, error
    localparam int ST_DONE_BIT   = 0;
    localparam int ST_BUSY_BIT   = 1;
    localparam int ST_ACTIVE_BIT = 2;
    localparam int ST_ABORT_BIT  = 3;
    localparam int ST_ERROR_BIT  = 4;

    // interrupt status bits
    localparam int IRQ_DONE_BIT   = 0;
    localparam int IRQ_ABORT_BIT  = 1;
    localparam int IRQ_ERROR_BIT  = 2;
    localparam int IRQ_REJECT_BIT = 3;

    // ------------------------------------------------------------
    // capture modes and fault codes
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_LOCAL_RISE = 4'h0;
    localparam logic [3:0] MODE_LOCAL_FALL = 4'h1;
    localparam logic [3:0] MODE_AUX_RISE   = 4'h5;
    localparam logic [3:0] MODE_AUX_FALL   = 4'h6;
    localparam logic [3:0] MODE_AUX_BOTH   = 4'h7;
    localparam logic [3:0] MODE_INDEX_RISE = 4'h8;

    localparam logic [15:0] FAULT_NONE = 16'h0000;
    localparam logic [15:0] FAULT_MODE = 16'h0001;
    localparam logic [15:0] FAULT_AXIS = 16'h0002;

    typedef enum {ATPC_IDLE, ATPC_BUSY, ATPC_ARMED, ATPC_HOLD} atpc_state_e;

endpackage : atpc_pkg

// ===== hdl/atpc_trig.sv
/*
 * atpc_trig: trigger edge detector of the touch-probe capture.
 * Assumes all inputs synchronous to clk_sys_in; gives a one-cycle
 * pulse on the edge that the mode selects.
 */
module atpc_trig (
    input  wire logic       clk_sys_in,     // system clock
    input  wire logic       rst_b_in,       // sync reset, active low
    input  wire logic [15:0] local_in,      // local inputs I0..I7, I10..I17
    input  wire logic       aux_in,         // drive aux input 13
    input  wire logic       index_in,       // drive encoder index
    input  wire logic [3:0] mode_in,        // captured mode
    input  wire logic [3:0] sel_in,         // local input select
    output logic            trig_out        // edge seen, one cycle
);
    import atpc_pkg::*;

    logic local_now;
    logic local_prev;
    logic aux_prev;
    logic index_prev;

    // ------------------------------------------------------------
    // input select and history
    // ------------------------------------------------------------
    // index 0..7 maps to I0..I7, 8..15 to I10..I17
    assign local_now = local_in[sel_in];

    // history runs always so the first armed edge is seen at once
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            local_prev <= 1'b0;
            aux_prev   <= 1'b0;
            index_prev <= 1'b0;
        end else begin
            local_prev <= local_now;
            aux_prev   <= aux_in;
            index_prev <= index_in;
        end
    end

    // ------------------------------------------------------------
    // edge per mode
    // ------------------------------------------------------------
    always_comb begin
        case (mode_in)
            MODE_LOCAL_RISE: trig_out = local_now & ~local_prev;
            MODE_LOCAL_FALL: trig_out = ~local_now & local_prev;
            MODE_AUX_RISE:   trig_out = aux_in & ~aux_prev;
            MODE_AUX_FALL:   trig_out = ~aux_in & aux_prev;
            MODE_AUX_BOTH:   trig_out = aux_in ^ aux_prev;
            MODE_INDEX_RISE: trig_out = index_in & ~index_prev;
            default:         trig_out = 1'b0;
        endcase
    end

endmodule : atpc_trig

// ===== tb/atpc_drive_model.sv
/* atpc_drive_model: servo drive and encoder port stand-in.
   Assumes the bench asks for aux levels and index pulses on rising edges. */
module atpc_drive_model (
    input  wire logic        clk_sys_in, // system clock
    input  wire logic        rst_b_in,   // sync reset, active low
    input  wire logic        aux_req_in, // wanted aux level
    input  wire logic        idx_req_in, // index pulse request
    output logic             aux_out,    // drive aux input 13
    output logic             index_out,  // encoder index
    output logic      [31:0] servo_out,  // feedback count
    output logic      [31:0] ext_out     // encoder port count
);
    timeunit 1ns;
    timeprecision 1ns;
    // counters start at 0 so the first delta after reset is not a jump
    always_ff @(posedge clk_sys_in) begin
        if (!rst_b_in) begin
            servo_out <= 32'h0;
            ext_out   <= 32'h0;
        end else begin
            servo_out <= servo_out + 32'h3;
            ext_out   <= ext_out + 32'h1;
        end
    end
    // aux follows its request a cycle late; index is a one-cycle pulse
    always_ff @(posedge clk_sys_in) begin
        aux_out   <= rst_b_in & aux_req_in;
        index_out <= rst_b_in & idx_req_in;
    end
endmodule : atpc_drive_model

// ===== tb/tb.sv
/* tb: self-checking bench of atpc_capture, apb master plus drive model.
   Assumes a scan period shortened to 4 clocks. */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import atpc_pkg::*;
    logic clk_sys_in = 0, rst_b_in = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, servo, ext, rd;
    logic pready, pslverr, aux_req = 0, idx_req = 0, abort_in = 0, aux, idx, err_seen;
    logic [15:0] local_in = 16'h0;
    logic done_out, busy_out, active_out, aborted_out, error_out, irq_out;
    int failures = 0, n_tests = 0;
    // flags that scenarios wait on: 0 active, 1 done, 2 busy, 3 aborted
    logic [3:0] flags;
    assign flags = {aborted_out, busy_out, done_out, active_out};
    always #2 clk_sys_in = ~clk_sys_in;
    atpc_capture #(.NUM_AXES(4), .SCAN_CYCLES(4)) atpc_capture_inst (.clk_sys_in(clk_sys_in),
        .rst_b_in(rst_b_in), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .local_inputs_in(local_in), .drive_aux_input_13_in(aux), .drive_index_in(idx),
        .ext_count_in(ext), .servo_count_in(servo), .abort_in(abort_in), .done_out(done_out),
        .busy_out(busy_out), .active_out(active_out), .aborted_out(aborted_out),
        .error_out(error_out), .irq_out(irq_out));
    atpc_drive_model atpc_drive_model_inst (.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
        .aux_req_in(aux_req), .idx_req_in(idx_req), .aux_out(aux), .index_out(idx),
        .servo_out(servo), .ext_out(ext));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask : check
    // one apb transfer; holds everything until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
        @(posedge clk_sys_in);
        penable <= 1'b1;
        @(posedge clk_sys_in);
        while (pready !== 1'b1) @(posedge clk_sys_in);
        rd = prdata;
        err_seen = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    // returns at the first edge at which flag k is seen high; a stuck flag ends the run
    task automatic wait_for(input int k);
        int i;
        i = 0;
        @(posedge clk_sys_in);
        while (flags[k] !== 1'b1 && i < 200) begin
            @(posedge clk_sys_in);
            i++;
        end
        if (flags[k] !== 1'b1) begin
            failures++;
            summarize();
        end
    endtask : wait_for
    // arm a capture, make the edge its mode asks for, expect done
    task automatic capture(input logic [3:0] m, input logic [3:0] s);
        local_in[s] <= (m == MODE_LOCAL_FALL);
        aux_req <= (m == MODE_AUX_FALL);
        apb(1, OFS_CTRL, 32'h0);
        apb(1, OFS_CTRL, {24'h0, m, 4'h1} | (32'(s) << 8));
        wait_for(0);
        check(busy_out, 1);
        @(posedge clk_sys_in);
        local_in[s] <= (m != MODE_LOCAL_FALL);
        aux_req <= (m != MODE_AUX_FALL);
        idx_req <= (m == MODE_INDEX_RISE);
        @(posedge clk_sys_in);
        idx_req <= 1'b0;
        wait_for(1);
        check({done_out, busy_out, active_out}, 3'b100);
        apb(0, OFS_POS_HI, 32'h0);
        check(rd != 32'h0, 1);
        $display("capture mode %0d done", m);
    endtask : capture
    task automatic faults_and_irq();
        apb(1, OFS_IRQ_MASK, 32'h1);
        capture(MODE_AUX_RISE, 4'h0);
        check(irq_out, 1);
        apb(1, OFS_IRQ_STAT, 32'hf);
        @(posedge clk_sys_in);
        check(irq_out, 0);
        apb(1, OFS_CTRL, 32'h0);
        apb(1, OFS_CTRL, 32'h31); // mode 3 is not a capture mode
        apb(0, OFS_FAULT, 32'h0);
        check({error_out, busy_out, rd[15:0]}, {2'b10, FAULT_MODE});
        apb(1, OFS_CTRL, 32'h0);
        apb(1, OFS_CTRL, 32'h51);
        apb(1, OFS_CTRL, 32'h50);
        apb(1, OFS_CTRL, 32'h51); // second start while busy
        apb(0, OFS_IRQ_STAT, 32'h0);
        check({busy_out, rd[IRQ_REJECT_BIT]}, 2'b11);
        wait_for(2);
        abort_in <= 1'b1;
        @(posedge clk_sys_in);
        abort_in <= 1'b0;
        wait_for(3);
        check({aborted_out, busy_out}, 2'b10);
        apb(0, 8'h40, 32'h0);
        check(err_seen, 1); // unmapped address answers with an error
        check(rd, 32'h0);
        $display("faults and irq done");
    endtask : faults_and_irq
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : summarize
    initial begin
        repeat (5) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        capture(MODE_LOCAL_RISE, 4'hf);
        capture(MODE_LOCAL_FALL, 4'h8);
        capture(MODE_AUX_RISE, 4'h0);
        capture(MODE_AUX_FALL, 4'h0);
        capture(MODE_AUX_BOTH, 4'h0);
        capture(MODE_INDEX_RISE, 4'h0);
        faults_and_irq();
        summarize();
    end
    // watchdog: the whole sequence needs a few hundred cycles
    initial begin
        #100000;
        failures++;
        summarize();
    end
endmodule : tb
